// ==== dv/hdlc_line_model.sv ====
// Line model: sends HDLC frames bit by bit to the receiver
`timescale 1ns/1ps
`default_nettype none
module hdlc_line_model (
   input wire logic clk,
   output logic rx_bit,
   output logic rx_bit_valid
);
   logic [7:0] tx_q[$];
   int ones;
   initial
   begin
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
   end
   // ==========================================
   // Bit every other clock; between bits the line shows the inverse
   task put_bit(input logic b);
      @(negedge clk);
      rx_bit <= b;
      rx_bit_valid <= 1'b1;
      @(negedge clk);
      rx_bit <= ~b;
      rx_bit_valid <= 1'b0;
   endtask
   task put_byte(input logic [7:0] v, input logic st);
      for (int j = 0; j < 8; j++)
      begin
         put_bit(v[j]);
         ones = (st && v[j]) ? ones + 1 : 0;
         if (ones == 5)
         begin
            put_bit(1'b0);
            ones = 0;
         end
      end
   endtask
   function automatic logic [15:0] fcs();
      logic [15:0] c;
      c = lapd_rx_pkg::CRC_INIT;
      foreach (tx_q[i])
         for (int j = 0; j < 8; j++)
            c = (c[0] ^ tx_q[i][j]) ? (c >> 1) ^ lapd_rx_pkg::CRC_POLY : c >> 1;
      return ~c;
   endfunction
   // One frame per call, never overlapped, so the window stays one
   task send_frame(input logic ab);
      logic [15:0] c;
      c = fcs();
      put_byte(8'h7e, 1'b0);
      foreach (tx_q[i])
         put_byte(tx_q[i], 1'b1);
      if (ab)
         repeat (7) put_bit(1'b1);
      else
      begin
         put_byte(c[7:0], 1'b1);
         put_byte(c[15:8], 1'b1);
      end
      put_byte(8'h7e, 1'b0);
   endtask
endmodule
`default_nettype wire

// ==== dv/lapd_receive_address_filter_tb.sv ====
// Self-checking bench for the receive address filter
`timescale 1ns/1ps
`default_nettype none
module lapd_receive_address_filter_tb;
   localparam logic [7:0] SA = 8'h10;
   localparam logic [7:0] SB = 8'h22;
   localparam logic [7:0] TA = 8'h45;
   localparam logic [7:0] TB = 8'h67;
   logic clk, rst_n, rx_bit, rx_bit_valid, pool_rd_ready, pool_rd_valid, pool_rd_last;
   logic mode_select_high, mode_select_mid, mode_select_low, ext, pol, pool_space_ok;
   logic frame_end, ack_request;
   logic [7:0] pool_rd_data, holder, status;
   logic [6:0] seq;
   logic [8:0] exp_q[$], got_q[$];
   logic [7:0] hi_t[7] = '{SA, 8'h12, SB, 8'h20, 8'hfe, 8'hfc, 8'h30};
   logic [7:0] lo_t[4] = '{TA, TB, 8'hff, 8'h11};
   int bad_count, n_checks, acks, ends;
   lapd_receive_address_filter #(.DEPTH(32)) lapd_receive_address_filter_i (.clk, .rst_n,
      .rx_bit, .rx_bit_valid, .mode_select_high, .mode_select_mid, .mode_select_low,
      .extended_control_format(ext), .cmd_resp_polarity_select(pol),
      .service_point_compare_a(SA), .service_point_compare_b(SB),
      .terminal_id_compare_a(TA), .terminal_id_compare_b(TB), .pool_rd_ready, .pool_rd_valid,
      .pool_rd_data, .pool_rd_last, .pool_space_ok, .receive_control_field_holder(holder),
      .receive_frame_status(status), .frame_end, .ack_request, .receive_seq_count(seq));
   hdlc_line_model hdlc_line_model_i (.clk, .rx_bit, .rx_bit_valid);
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(negedge clk)
   begin
      if (ack_request === 1'b1)
         acks++;
      if (frame_end === 1'b1)
         ends++;
   end
   // ==========================================
   // Checks and expectations
   task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_word(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task stop_test();
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [8:0] addr_exp(input logic [7:0] h, l, input logic p);
      logic a1, b1, g1, a2, b2, g2;
      a1 = (h | 8'h02) == (SA | 8'h02);
      b1 = (h | 8'h02) == (SB | 8'h02);
      g1 = (h | lapd_rx_pkg::CR_MASK) == lapd_rx_pkg::GROUP_SAPI_A;
      a2 = l == TA;
      b2 = l == TB;
      g2 = l == lapd_rx_pkg::GROUP_TEI;
      return {(a1 && (a2 || g2)) || (b1 && (b2 || g2)) || (g1 && (a2 || b2 || g2)), 4'ha,
         h[1] ^ p, b1, b2, g1 || g2};
   endfunction
   task set_mode(input logic [2:0] m, input logic e);
      @(negedge clk);
      {mode_select_high, mode_select_mid, mode_select_low} <= m;
      ext <= e;
   endtask
   task drain();
      logic r;
      repeat (300)
      begin
         @(negedge clk);
         r = ($urandom % 3) != 0;
         pool_rd_ready <= r;
         if (pool_rd_valid === 1'b1 && r)
            got_q.push_back({pool_rd_last, pool_rd_data});
      end
      @(negedge clk);
      pool_rd_ready <= 1'b0;
   endtask
   task cmp_data();
      chk_reg("pool words", 8'(exp_q.size()), 8'(got_q.size()));
      foreach (exp_q[i])
         if (i < got_q.size())
            chk_word("pool word", exp_q[i], got_q[i]);
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic run(input logic [2:0] m, input logic e, input logic [7:0] b0, b1, b2,
      input int n, skip, input logic keep, input logic [7:0] st, msk);
      logic [7:0] d;
      logic [15:0] c;
      logic [8:0] w;
      int e0;
      set_mode(m, e);
      hdlc_line_model_i.tx_q = {b0, b1, b2};
      repeat (n)
      begin
         d = $urandom;
         hdlc_line_model_i.tx_q.push_back(d);
      end
      c = hdlc_line_model_i.fcs();
      if (keep)
         for (int i = skip; i < hdlc_line_model_i.tx_q.size(); i++)
            exp_q.push_back({1'b0, hdlc_line_model_i.tx_q[i]});
      if (keep && m == lapd_rx_pkg::MODE_TRANS_ALL)
      begin
         exp_q.push_back({1'b0, c[7:0]});
         exp_q.push_back({1'b0, c[15:8]});
      end
      e0 = ends;
      hdlc_line_model_i.send_frame(1'b0);
      repeat (10) @(negedge clk);
      chk_reg("frame ends", {7'h0, keep}, 8'(ends - e0));
      if (keep)
         chk_reg("frame status", st & msk, status & msk);
      if (keep && !m[2])
         chk_reg("control holder", hdlc_line_model_i.tx_q[skip - 1], holder);
      if (keep)
         exp_q.push_back({1'b1, st & msk});
      drain();
      if (keep && got_q.size() > 0)
      begin
         w = got_q.pop_back();
         got_q.push_back({w[8], w[7:0] & msk});
      end
      cmp_data();
   endtask
   // ==========================================
   // Scenarios
   initial
   begin
      logic [8:0] a;
      logic [7:0] d;
      {mode_select_high, mode_select_mid, mode_select_low} = 3'h3;
      ext = 1'b0;
      pol = 1'b0;
      pool_rd_ready = 1'b0;
      rst_n = 1'b0;
      bad_count = 0;
      n_checks = 0;
      acks = 0;
      ends = 0;
      void'($urandom(55));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      foreach (hi_t[i])
         foreach (lo_t[j])
         begin
            pol = $urandom;
            a = addr_exp(hi_t[i], lo_t[j], pol);
            run(3'h3, 0, hi_t[i], lo_t[j], 8'h03, 2, 3, a[8], a[7:0], 8'hff);
         end
      pol = 1'b0;
      run(3'h2, 0, TA, 8'h03, 8'h5a, 2, 2, 1, 8'ha8, 8'hf8);
      run(3'h2, 0, TB, 8'h03, 8'h5a, 2, 2, 1, 8'ha0, 8'hf8);
      run(3'h2, 0, SA, 8'h03, 8'h5a, 2, 2, 0, 8'h00, 8'h00);
      run(3'h0, 0, TB, 8'h01, 8'h5a, 2, 2, 1, 8'ha0, 8'hf8);
      run(3'h5, 0, 8'h55, TA, 8'h33, 3, 2, 1, 8'ha0, 8'he0);
      run(3'h5, 0, 8'h55, 8'hff, 8'h33, 3, 2, 1, 8'ha0, 8'he0);
      run(3'h5, 0, TA, 8'h12, 8'h33, 3, 2, 0, 8'h00, 8'h00);
      run(3'h7, 0, SB ^ 8'h02, 8'h9a, 8'h01, 3, 1, 1, 8'ha0, 8'he0);
      run(3'h7, 0, 8'hfc, 8'h9a, 8'h01, 3, 1, 1, 8'ha0, 8'he0);
      run(3'h7, 0, TA, 8'h9a, 8'h01, 3, 1, 0, 8'h00, 8'h00);
      run(3'h6, 0, 8'($urandom), 8'h7e, 8'hff, 4, 0, 1, 8'ha0, 8'he0);
      run(3'h4, 0, SA, TA, 8'h03, 2, 3, 0, 8'h00, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         run(3'h1, 0, SA, TA, {4'h0, k[2:0], 1'b0}, 2, 3, 1, 8'ha0, 8'hfe);
         chk_reg("seq count", 8'(k + 1), {1'b0, seq});
      end
      run(3'h1, 1, SA, TA, 8'h04, 2, 3, 1, 8'ha0, 8'hfe);
      run(3'h1, 0, SB, TB, 8'h06, 2, 3, 1, 8'hae, 8'hfe);
      chk_reg("acks", 8'h03, 8'(acks));
      fork
         run(3'h6, 0, 8'h01, 8'h02, 8'h03, 3, 0, 1, 8'ha0, 8'he0);
         begin
            repeat (40) @(negedge clk);
            {mode_select_high, mode_select_mid, mode_select_low} = 3'h4;
         end
      join
      set_mode(3'h6, 1'b0);
      hdlc_line_model_i.tx_q = {8'h11, 8'h22, 8'h33};
      hdlc_line_model_i.send_frame(1'b1);
      repeat (10) @(negedge clk);
      chk_reg("abort", 8'h01, {7'h0, status[lapd_rx_pkg::ST_ABORT]});
      drain();
      got_q.delete();
      hdlc_line_model_i.tx_q.delete();
      for (int i = 0; i < 40; i++)
      begin
         d = $urandom;
         hdlc_line_model_i.tx_q.push_back(d);
         if (i < 32)
            exp_q.push_back({1'b0, d});
      end
      hdlc_line_model_i.send_frame(1'b0);
      repeat (10) @(negedge clk);
      chk_reg("space", 8'h00, {7'h0, pool_space_ok});
      chk_reg("overflow", 8'h01, {7'h0, status[lapd_rx_pkg::ST_OVF]});
      drain();
      cmp_data();
      chk_reg("empty", 8'h00, {7'h0, pool_rd_valid});
      stop_test();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire

// ==== dv/rx_filter_monitor.sv ====
// Port assertions for the receive address filter
`timescale 1ns/1ps
`default_nettype none
module rx_filter_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_bit_valid,
   input wire logic pool_rd_ready,
   input wire logic pool_rd_valid,
   input wire logic [7:0] pool_rd_data,
   input wire logic pool_rd_last,
   input wire logic pool_space_ok,
   input wire logic [7:0] receive_frame_status,
   input wire logic frame_end,
   input wire logic ack_request,
   input wire logic [6:0] receive_seq_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Properties
   property p_end_pulse; frame_end |=> !frame_end; endproperty
   property p_ack_end; ack_request |-> frame_end; endproperty
   property p_st_end; $changed(receive_frame_status) |-> frame_end; endproperty
   property p_seq_ack; $changed(receive_seq_count) |-> ack_request || $past(ack_request); endproperty
   property p_empty_space; !pool_rd_valid |-> pool_space_ok; endproperty
   property p_head_hold;
      pool_rd_valid && !pool_rd_ready |=> pool_rd_valid && $stable(pool_rd_data)
         && $stable(pool_rd_last);
   endproperty
   property p_wr_bit; $rose(pool_rd_valid) |-> $past(rx_bit_valid); endproperty
   property p_full_hold; !pool_space_ok && !pool_rd_ready |=> !pool_space_ok; endproperty
   property p_end_bit; frame_end |-> $past(rx_bit_valid); endproperty
   a_end_pulse: assert property (p_end_pulse) else $error("frame end too long");
   a_ack_end: assert property (p_ack_end) else $error("ack without frame end");
   a_st_end: assert property (p_st_end) else $error("status moved off frame end");
   a_seq_ack: assert property (p_seq_ack) else $error("count moved without ack");
   a_empty_space: assert property (p_empty_space) else $error("empty pool full");
   a_head_hold: assert property (p_head_hold) else $error("pool head moved");
   a_wr_bit: assert property (p_wr_bit) else $error("pool write without bit");
   a_full_hold: assert property (p_full_hold) else $error("space without pop");
   a_end_bit: assert property (p_end_bit) else $error("frame end without bit");
   c_end: cover property (frame_end);
   c_ack: cover property (ack_request);
   c_full: cover property (!pool_space_ok);
   c_ovf: cover property (frame_end && receive_frame_status[lapd_rx_pkg::ST_OVF]);
endmodule
bind lapd_receive_address_filter rx_filter_monitor rx_filter_monitor_i (.clk(clk), .rst_n(rst_n),
   .rx_bit_valid(rx_bit_valid), .pool_rd_ready(pool_rd_ready), .pool_rd_valid(pool_rd_valid),
   .pool_rd_data(pool_rd_data), .pool_rd_last(pool_rd_last), .pool_space_ok(pool_space_ok),
   .receive_frame_status(receive_frame_status), .frame_end(frame_end),
   .ack_request(ack_request), .receive_seq_count(receive_seq_count));
`default_nettype wire

// ==== pkg/lapd_rx_pkg.sv ====
// Constants and types shared by the D-channel receive address filter
package lapd_rx_pkg;
   // ==========================================
   // Mode codes
   localparam logic [1:0] MODE_HI_AUTO = 2'h0;
   localparam logic [1:0] MODE_HI_NONAUTO = 2'h1;
   localparam logic [2:0] MODE_UNUSED = 3'h4;
   localparam logic [2:0] MODE_TRANS_TEI = 3'h5;
   localparam logic [2:0] MODE_TRANS_ALL = 3'h6;
   localparam logic [2:0] MODE_TRANS_SAPI = 3'h7;
   // ==========================================
   // Address values
   localparam logic [7:0] GROUP_SAPI_A = 8'hfe;
   localparam logic [7:0] GROUP_SAPI_B = 8'hfc;
   localparam logic [7:0] GROUP_TEI = 8'hff;
   localparam logic [7:0] CR_MASK = 8'h02;
   localparam int CR_BIT = 1;
   // ==========================================
   // Line coding and check sequence
   localparam logic [2:0] ONES_FLAG = 3'h6;
   localparam logic [2:0] ONES_STUFF = 3'h5;
   localparam logic [2:0] ONES_MAX = 3'h7;
   localparam logic [3:0] FILL_FULL = 4'he;
   localparam logic [3:0] FILL_CRC = 4'h7;
   localparam logic [2:0] PHASE_BYTE = 3'h6;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_GOOD = 16'hf0b8;
   // ==========================================
   // Frame status bit positions
   localparam int ST_ALIGN = 7;
   localparam int ST_OVF = 6;
   localparam int ST_CRC = 5;
   localparam int ST_ABORT = 4;
   localparam int ST_CMD = 3;
   localparam int ST_SAPI_B = 2;
   localparam int ST_TEI_B = 1;
   localparam int ST_GROUP = 0;
   // ==========================================
   // Reset values and sizes
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [6:0] SEQ_RESET = 7'h00;
   localparam int POOL_DEPTH = 64;
   localparam int POOL_WIDTH = 9;
   typedef enum logic [2:0] {ST_HUNT, ST_ADDR_HI, ST_ADDR_LO, ST_CTRL, ST_DATA, ST_DROP} rx_state_t;
endpackage

// ==== rtl/lapd_receive_address_filter.sv ====
// D-channel receiver: flags, destuffing, check sequence, address filter
`timescale 1ns/1ps
`default_nettype none
module lapd_receive_address_filter #(
   parameter int DEPTH = lapd_rx_pkg::POOL_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   input wire logic mode_select_high,
   input wire logic mode_select_mid,
   input wire logic mode_select_low,
   input wire logic extended_control_format,
   input wire logic cmd_resp_polarity_select,
   input wire logic [7:0] service_point_compare_a,
   input wire logic [7:0] service_point_compare_b,
   input wire logic [7:0] terminal_id_compare_a,
   input wire logic [7:0] terminal_id_compare_b,
   input wire logic pool_rd_ready,
   output logic pool_rd_valid,
   output logic [7:0] pool_rd_data,
   output logic pool_rd_last,
   output logic pool_space_ok,
   output logic [7:0] receive_control_field_holder,
   output logic [7:0] receive_frame_status,
   output logic frame_end,
   output logic ack_request,
   output logic [6:0] receive_seq_count
);
   typedef struct packed {
      logic [13:0] sh;
      logic [3:0] fill;
      logic [2:0] ph;
      logic [2:0] ones;
      logic in_frame;
      logic any;
      logic [15:0] crc;
      logic [2:0] mode;
      logic ecf;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [1:0] nb;
      lapd_rx_pkg::rx_state_t st;
      logic [2:0] hit_s;
      logic [2:0] hit_t;
      logic cmd;
      logic auto_conn;
      logic iframe;
      logic ns_ok;
      logic ovf;
      logic [7:0] hold;
      logic [7:0] stat;
      logic fend;
      logic ack;
      logic [6:0] vr;
   } core_t;

   core_t r;
   core_t n;
   logic [1:0] rst_sync;
   logic rst_n_int;
   logic wr_valid;
   logic wr_ready;
   logic [8:0] wr_data;
   logic [8:0] rd_word;
   logic [2:0] mode_in;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[0] ^ b;
      crc_step = fb ? ((c >> 1) ^ lapd_rx_pkg::CRC_POLY) : (c >> 1);
   endfunction

   function automatic logic sapi_eq(input logic [7:0] a, input logic [7:0] b);
      sapi_eq = (a & ~lapd_rx_pkg::CR_MASK) == (b & ~lapd_rx_pkg::CR_MASK);
   endfunction

   // ==========================================
   // Reset release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync <= 2'h0;
      end
      else
      begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync[1];
   assign mode_in = {mode_select_high, mode_select_mid, mode_select_low};

   // ==========================================
   // Receive core
   always_comb
   begin
      logic data_ev;
      logic flag;
      logic abort;
      logic byte_ev;
      logic ob_ev;
      logic [7:0] eb;
      logic [7:0] ob;
      logic [6:0] ns;
      logic valid2;
      logic done;
      logic [7:0] stat;
      n = r;
      data_ev = 1'b0;
      flag = 1'b0;
      abort = 1'b0;
      byte_ev = 1'b0;
      ob_ev = 1'b0;
      eb = 8'h00;
      ob = 8'h00;
      ns = 7'h00;
      valid2 = 1'b0;
      done = 1'b0;
      stat = 8'h00;
      wr_valid = 1'b0;
      wr_data = 9'h000;
      n.fend = 1'b0;
      n.ack = 1'b0;
      if (rx_bit_valid)
      begin
         if (rx_bit)
         begin
            n.ones = (r.ones == lapd_rx_pkg::ONES_MAX) ? r.ones : r.ones + 3'h1;
            abort = r.ones == lapd_rx_pkg::ONES_FLAG;
            data_ev = r.ones < lapd_rx_pkg::ONES_STUFF;
         end
         else
         begin
            n.ones = 3'h0;
            flag = r.ones == lapd_rx_pkg::ONES_FLAG;
            data_ev = r.ones < lapd_rx_pkg::ONES_STUFF;
         end
      end
      // Data bits lag by six so that flag bits never reach a byte
      if (data_ev && r.in_frame)
      begin
         n.sh = {rx_bit, r.sh[13:1]};
         n.fill = (r.fill == lapd_rx_pkg::FILL_FULL) ? r.fill : r.fill + 4'h1;
         n.ph = r.ph + 3'h1;
         if (n.fill >= lapd_rx_pkg::FILL_CRC)
         begin
            n.crc = crc_step(r.crc, n.sh[7]);
         end
         if (n.fill == lapd_rx_pkg::FILL_FULL && n.ph == lapd_rx_pkg::PHASE_BYTE)
         begin
            byte_ev = 1'b1;
            eb = n.sh[7:0];
         end
      end
      // Except in MODE_TRANS_ALL, two bytes are held back so the check sequence is not stored
      if (byte_ev)
      begin
         n.any = 1'b1;
         if (r.mode == lapd_rx_pkg::MODE_TRANS_ALL)
         begin
            ob_ev = 1'b1;
            ob = eb;
         end
         else
         begin
            ob_ev = r.nb == 2'h2;
            ob = r.d2;
            n.d2 = r.d1;
            n.d1 = eb;
            n.nb = (r.nb == 2'h2) ? r.nb : r.nb + 2'h1;
         end
      end
      if (ob_ev)
      begin
         unique case (r.st)
            lapd_rx_pkg::ST_HUNT, lapd_rx_pkg::ST_DROP:
            begin
               n.st = r.st;
            end
            lapd_rx_pkg::ST_ADDR_HI:
            begin
               n.hit_s[0] = sapi_eq(ob, service_point_compare_a);
               n.hit_s[1] = sapi_eq(ob, service_point_compare_b);
               n.hit_s[2] = sapi_eq(ob, lapd_rx_pkg::GROUP_SAPI_A)
                  || sapi_eq(ob, lapd_rx_pkg::GROUP_SAPI_B);
               n.cmd = ob[lapd_rx_pkg::CR_BIT] ^ cmd_resp_polarity_select;
               if (r.mode == lapd_rx_pkg::MODE_TRANS_SAPI)
               begin
                  n.st = (n.hit_s != 3'h0) ? lapd_rx_pkg::ST_DATA : lapd_rx_pkg::ST_DROP;
               end
               else if (r.mode == lapd_rx_pkg::MODE_TRANS_TEI)
               begin
                  n.st = lapd_rx_pkg::ST_ADDR_LO;
               end
               else if (r.mode[0])
               begin
                  n.st = lapd_rx_pkg::ST_ADDR_LO;
               end
               else
               begin
                  n.hit_s = 3'h0;
                  n.hit_t[0] = ob == terminal_id_compare_a;
                  n.hit_t[1] = ob == terminal_id_compare_b;
                  n.hit_t[2] = 1'b0;
                  n.cmd = n.hit_t[0];
                  n.st = (n.hit_t[1:0] != 2'h0) ? lapd_rx_pkg::ST_CTRL : lapd_rx_pkg::ST_DROP;
               end
            end
            lapd_rx_pkg::ST_ADDR_LO:
            begin
               n.hit_t[0] = ob == terminal_id_compare_a;
               n.hit_t[1] = ob == terminal_id_compare_b;
               n.hit_t[2] = ob == lapd_rx_pkg::GROUP_TEI;
               valid2 = (r.hit_s[0] && (n.hit_t[0] || n.hit_t[2]))
                  || (r.hit_s[1] && (n.hit_t[1] || n.hit_t[2]))
                  || (r.hit_s[2] && (n.hit_t != 3'h0));
               if (r.mode == lapd_rx_pkg::MODE_TRANS_TEI)
               begin
                  n.hit_s = 3'h0;
                  n.st = (n.hit_t != 3'h0) ? lapd_rx_pkg::ST_DATA : lapd_rx_pkg::ST_DROP;
               end
               else
               begin
                  n.st = valid2 ? lapd_rx_pkg::ST_CTRL : lapd_rx_pkg::ST_DROP;
                  n.auto_conn = r.mode[2:1] == lapd_rx_pkg::MODE_HI_AUTO
                     && r.hit_s[0] && n.hit_t[0];
               end
            end
            lapd_rx_pkg::ST_CTRL:
            begin
               n.hold = ob;
               n.iframe = !ob[0];
               ns = r.ecf ? ob[7:1] : {4'h0, ob[3:1]};
               n.ns_ok = ns == r.vr;
               n.st = lapd_rx_pkg::ST_DATA;
            end
            lapd_rx_pkg::ST_DATA:
            begin
               wr_valid = 1'b1;
               wr_data = {1'b0, ob};
               if (!wr_ready)
               begin
                  n.ovf = 1'b1;
               end
            end
         endcase
      end
      // Frame end on closing flag or abort
      if ((flag || abort) && r.in_frame && r.any)
      begin
         done = r.st == lapd_rx_pkg::ST_DATA;
         stat[lapd_rx_pkg::ST_ALIGN] = flag && r.ph == lapd_rx_pkg::PHASE_BYTE;
         stat[lapd_rx_pkg::ST_OVF] = r.ovf || !wr_ready;
         stat[lapd_rx_pkg::ST_CRC] = r.crc == lapd_rx_pkg::CRC_GOOD;
         stat[lapd_rx_pkg::ST_ABORT] = abort;
         stat[lapd_rx_pkg::ST_CMD] = r.cmd;
         stat[lapd_rx_pkg::ST_SAPI_B] = r.hit_s[1];
         stat[lapd_rx_pkg::ST_TEI_B] = r.hit_t[1];
         stat[lapd_rx_pkg::ST_GROUP] = r.hit_s[2] || r.hit_t[2];
         if (done)
         begin
            wr_valid = 1'b1;
            wr_data = {1'b1, stat};
            n.stat = stat;
            n.fend = 1'b1;
            if (r.auto_conn && r.iframe && r.ns_ok && stat[lapd_rx_pkg::ST_CRC]
               && stat[lapd_rx_pkg::ST_ALIGN])
            begin
               n.vr = r.ecf ? r.vr + 7'h1 : {4'h0, r.vr[2:0] + 3'h1};
               n.ack = 1'b1;
            end
         end
      end
      if (abort)
      begin
         n.in_frame = 1'b0;
      end
      // Opening flag latches the mode for the whole frame
      if (flag)
      begin
         n.in_frame = 1'b1;
         n.any = 1'b0;
         n.fill = 4'h0;
         n.ph = 3'h0;
         n.nb = 2'h0;
         n.crc = lapd_rx_pkg::CRC_INIT;
         n.mode = mode_in;
         n.ecf = extended_control_format;
         n.hit_s = 3'h0;
         n.hit_t = 3'h0;
         n.cmd = 1'b0;
         n.auto_conn = 1'b0;
         n.iframe = 1'b0;
         n.ns_ok = 1'b0;
         n.ovf = 1'b0;
         if (mode_in == lapd_rx_pkg::MODE_TRANS_ALL)
         begin
            n.st = lapd_rx_pkg::ST_DATA;
         end
         else if (mode_in == lapd_rx_pkg::MODE_UNUSED)
         begin
            n.st = lapd_rx_pkg::ST_DROP;
         end
         else
         begin
            n.st = lapd_rx_pkg::ST_ADDR_HI;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         r <= '0;
         r.st <= lapd_rx_pkg::ST_HUNT;
         r.crc <= lapd_rx_pkg::CRC_INIT;
         r.hold <= lapd_rx_pkg::HOLD_RESET;
         r.stat <= lapd_rx_pkg::STATUS_RESET;
         r.vr <= lapd_rx_pkg::SEQ_RESET;
      end
      else
      begin
         r <= n;
      end
   end

   // ==========================================
   // Receive pool
   rx_pool_fifo #(
      .WIDTH(lapd_rx_pkg::POOL_WIDTH),
      .DEPTH(DEPTH)
   ) u_pool (
      .clk(clk),
      .rst_n(rst_n_int),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(pool_rd_valid),
      .out_ready(pool_rd_ready),
      .out_data(rd_word)
   );

   // ==========================================
   // Outputs
   assign pool_rd_data = rd_word[7:0];
   assign pool_rd_last = rd_word[8];
   assign pool_space_ok = wr_ready;
   assign receive_control_field_holder = r.hold;
   assign receive_frame_status = r.stat;
   assign frame_end = r.fend;
   assign ack_request = r.ack;
   assign receive_seq_count = r.vr;
endmodule
`default_nettype wire

// ==== rtl/rx_pool_fifo.sv ====
// Receive pool buffer: synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rx_pool_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } fifo_t;

   fifo_t r;
   fifo_t n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // ==========================================
   // Handshake
   assign in_ready = r.count != (AW+1)'(DEPTH);
   assign out_valid = r.count != '0;
   assign out_data = mem[r.rptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      n = r;
      if (push)
      begin
         n.wptr = r.wptr + 1'b1;
      end
      if (pop)
      begin
         n.rptr = r.rptr + 1'b1;
      end
      if (push && !pop)
      begin
         n.count = r.count + 1'b1;
      end
      else if (pop && !push)
      begin
         n.count = r.count - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

   // ==========================================
   // Storage
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[r.wptr] <= in_data;
      end
   end
endmodule
`default_nettype wire
